// file: src/ebtc_pkg.sv
// Constants for the eight-bit timer/counter: register map, field positions,
// reset values and instruction-cycle phase numbers.
// Assumes a 32-bit APB master on the same clock as the block.
package ebtc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_COUNT  = 10'h001;
  localparam logic [9:0] IDX_INTCTL = 10'h00b;
  localparam logic [9:0] IDX_OPTION = 10'h081;
  localparam logic [9:0] IDX_STATUS = 10'h040;
  localparam logic [9:0] IDX_CLEAR  = 10'h041;
  localparam logic [9:0] IDX_ENABLE = 10'h042;
  // Reset values
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  // Option configuration fields
  localparam int unsigned OPT_CS_BIT   = 5;
  localparam int unsigned OPT_SE_BIT   = 4;
  localparam int unsigned OPT_PSA_BIT  = 3;
  localparam int unsigned OPT_RATE_LSB = 0;
  localparam int unsigned RATE_W       = 3;
  // Interrupt control fields
  localparam int unsigned INT_EN_BIT   = 5;
  localparam int unsigned INT_FLAG_BIT = 2;
  // Event status / clear / enable layout
  localparam int unsigned EVT_OVF_BIT  = 0;
  // Four phase clocks per instruction cycle, one pclk each
  localparam logic [1:0] PHASE_SECOND = 2'h1;
  localparam logic [1:0] PHASE_FOURTH = 2'h3;
  localparam logic [1:0] STALL_CYCLES = 2'h2;
  localparam logic [7:0] COUNT_MAX    = 8'hff;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction
endpackage

// file: src/ebtc_top.sv
// Eight-bit timer/counter with shared prescaler, APB register slave and
// level interrupt output.
// Assumes ext_count_input is already a digital level and asynchronous to pclk.
//
// Contract
// - Clock select zero counts one per instruction cycle without prescaler.
// - A count register write stalls counting for two instruction cycles.
// - Clock select one counts edges of the external count input.
// - Edge select zero counts rising edges, one counts falling edges.
// - Eight-bit counter; wrap from ff to 00 sets the overflow flag.
// - Overflow request is blocked while its enable is zero; flag still sets.
// - Overflow flag stays set until software clears it.
// - Counter halts during sleep, so overflow never wakes the core.
// - Prescaler output is sampled on the second and fourth phase clocks.
// - Without prescaler, the external input feeds the sampler directly.
// - Count register readable and writable; eight-bit prescaler available.
// - Prescaler assign zero routes prescaler to counter, one to watchdog.
// - Rate code 000 gives 1:2, doubling per step to 1:256.
// - Count write clears prescaler when assigned; prescaler not accessible.
`timescale 1ns/1ps

module ebtc_top
  import ebtc_pkg::*;
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ebtc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ebtc_pkg::DATA_W-1:0]  pwdata,
  output logic      [ebtc_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         sleep_mode,
  input  wire logic                         ext_count_input,
  output logic                              overflow_int_req,
  output logic                              irq
);
  import ebtc_pkg::*;

  typedef struct packed {
    logic [1:0]        phase;
    logic              pin_s1;
    logic              pin_s2;
    logic              src_prev;
    logic [7:0]        pre;
    logic              samp;
    logic [1:0]        stall;
    logic [7:0]        count;
    logic [7:0]        intctl;
    logic [7:0]        option;
    logic              status;
    logic              enable;
    logic [DATA_W-1:0] rdata;
  } ebtc_state_type;

  ebtc_state_type s_q;
  ebtc_state_type s_d;

  // ==========================================================
  // Decode and datapath terms
  logic              wr_acc;
  logic              setup;
  logic              mapped;
  logic              wr_count;
  logic              wr_intctl;
  logic              wr_clear;
  logic              cs;
  logic              bypass;
  logic              src_level;
  logic              pre_out;
  logic              sample_now;
  logic              inc;
  logic              ovf;
  logic [RATE_W-1:0] rate;

  always_comb begin
    setup     = psel && !penable;
    wr_acc    = psel && penable && pwrite;
    mapped    = reg_hit(paddr, IDX_COUNT) || reg_hit(paddr, IDX_INTCTL) ||
                reg_hit(paddr, IDX_OPTION) || reg_hit(paddr, IDX_STATUS) ||
                reg_hit(paddr, IDX_CLEAR) || reg_hit(paddr, IDX_ENABLE);
    wr_count  = wr_acc && reg_hit(paddr, IDX_COUNT);
    wr_intctl = wr_acc && reg_hit(paddr, IDX_INTCTL);
    wr_clear  = wr_acc && reg_hit(paddr, IDX_CLEAR);
    cs        = s_q.option[OPT_CS_BIT];
    bypass    = s_q.option[OPT_PSA_BIT];
    rate      = s_q.option[OPT_RATE_LSB +: RATE_W];
    // Timer source is the instruction clock, high in the last two phases
    src_level = cs ? (s_q.pin_s2 ^ s_q.option[OPT_SE_BIT]) : s_q.phase[1];
    pre_out   = bypass ? src_level : s_q.pre[rate];
    sample_now = (s_q.phase == PHASE_SECOND) || (s_q.phase == PHASE_FOURTH);
    inc       = sample_now && pre_out && !s_q.samp && (s_q.stall == 2'h0) &&
                !sleep_mode;
    ovf       = inc && (s_q.count == COUNT_MAX) && !wr_count;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d        = s_q;
    s_d.phase  = s_q.phase + 2'h1;
    // Two-flop synchroniser; only the second stage is used
    s_d.pin_s1 = ext_count_input;
    s_d.pin_s2 = s_q.pin_s1;

    // Prescaler frozen in sleep and while lent to the watchdog
    if (!sleep_mode && !bypass) begin
      s_d.src_prev = src_level;
      if (src_level && !s_q.src_prev) begin
        s_d.pre = s_q.pre + 8'h01;
      end
    end else begin
      s_d.src_prev = src_level;
    end
    if (wr_count && !bypass) begin
      s_d.pre = 8'h00;
    end

    if (sample_now && !sleep_mode) begin
      s_d.samp = pre_out;
    end

    if (s_q.phase == PHASE_FOURTH && s_q.stall != 2'h0) begin
      s_d.stall = s_q.stall - 2'h1;
    end

    if (inc) begin
      s_d.count = s_q.count + 8'h01;
    end

    if (wr_count) begin
      s_d.count = pwdata[7:0];
      s_d.stall = STALL_CYCLES;
    end
    if (wr_acc && reg_hit(paddr, IDX_OPTION)) begin
      s_d.option = pwdata[7:0];
    end
    if (wr_intctl) begin
      s_d.intctl = pwdata[7:0];
    end
    // Overflow set beats a same-cycle software clear
    if (ovf) begin
      s_d.intctl[INT_FLAG_BIT] = 1'b1;
      s_d.status = 1'b1;
    end else if (wr_clear && pwdata[EVT_OVF_BIT]) begin
      s_d.status = 1'b0;
    end
    if (wr_acc && reg_hit(paddr, IDX_ENABLE)) begin
      s_d.enable = pwdata[EVT_OVF_BIT];
    end

    // Read data captured in setup so it is stable for the access phase
    if (setup) begin
      s_d.rdata = '0;
      if (reg_hit(paddr, IDX_COUNT)) begin
        s_d.rdata[7:0] = s_q.count;
      end
      if (reg_hit(paddr, IDX_INTCTL)) begin
        s_d.rdata[7:0] = s_q.intctl;
      end
      if (reg_hit(paddr, IDX_OPTION)) begin
        s_d.rdata[7:0] = s_q.option;
      end
      if (reg_hit(paddr, IDX_STATUS)) begin
        s_d.rdata[EVT_OVF_BIT] = s_q.status;
      end
      if (reg_hit(paddr, IDX_ENABLE)) begin
        s_d.rdata[EVT_OVF_BIT] = s_q.enable;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.count  <= COUNT_RST;
      s_q.intctl <= INTCTL_RST;
      s_q.option <= OPTION_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // Sleep stops the counter, so only a software write to the interrupt control register can raise this request while asleep
  assign overflow_int_req = s_q.intctl[INT_FLAG_BIT] && s_q.intctl[INT_EN_BIT];
  assign irq     = s_q.status && s_q.enable;

  // ==========================================================
  // Assertions
  sequence count_write_s;
    wr_count;
  endsequence

  sequence no_count_s;
    (!inc) [*4];
  endsequence

  timer_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!cs && bypass && !sleep_mode && s_q.phase == PHASE_FOURTH && s_q.stall == 2'h0 && !s_q.samp)
      |-> inc)
    else $error("timer mode missed an instruction cycle tick");

  write_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    count_write_s |=> no_count_s)
    else $error("count advanced right after a count write");

  counter_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cs && inc) |-> (s_q.phase == PHASE_SECOND || s_q.phase == PHASE_FOURTH))
    else $error("counter mode step outside a sample phase");

  edge_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cs && bypass && inc) |-> (s_q.pin_s2 != s_q.option[OPT_SE_BIT]))
    else $error("counted edge does not match edge select");

  wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (inc && s_q.count == COUNT_MAX && !wr_count) |=> (s_q.count == 8'h00 && s_q.intctl[INT_FLAG_BIT]))
    else $error("wrap did not clear count and set flag");

  irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.intctl[INT_EN_BIT] |-> !overflow_int_req)
    else $error("overflow request while disabled");

  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.intctl[INT_FLAG_BIT] && !wr_intctl) |=> s_q.intctl[INT_FLAG_BIT])
    else $error("overflow flag dropped without software clear");

  sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_mode && !wr_count) |=> $stable(s_q.count))
    else $error("count moved during sleep");

  sample_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(s_q.samp) |-> ($past(s_q.phase) == PHASE_SECOND || $past(s_q.phase) == PHASE_FOURTH))
    else $error("sampler updated outside second or fourth phase");

  pre_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_count && !bypass) |=> (s_q.pre == 8'h00))
    else $error("prescaler not cleared by count write");

  req_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.intctl[INT_FLAG_BIT] && s_q.intctl[INT_EN_BIT]) |-> overflow_int_req)
    else $error("request missing with flag and enable set");

  // ==========================================================
  // Bus, event and prescaler assertions
  // Load checks look one edge back, at the bus value of the access cycle

  sequence ovf_event_s;
    ovf;
  endsequence

  count_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_count |=> (s_q.count == $past(pwdata[7:0])))
    else $error("count write did not load the written value");

  timer_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!cs && bypass && inc) |-> (s_q.phase == PHASE_FOURTH))
    else $error("timer step outside the fourth phase");

  pre_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!bypass && inc) |-> s_q.pre[rate])
    else $error("prescaled step without selected prescaler bit");

  pre_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    bypass |=> $stable(s_q.pre))
    else $error("prescaler moved while lent to the watchdog");

  pre_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_mode && !wr_count) |=> $stable(s_q.pre))
    else $error("prescaler moved during sleep");

  sleep_samp_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_mode |=> $stable(s_q.samp))
    else $error("sampler moved during sleep");

  ovf_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_event_s |=> s_q.status)
    else $error("wrap did not set the status bit");

  status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ovf && wr_clear && pwdata[EVT_OVF_BIT]) |=> !s_q.status)
    else $error("status clear write had no effect");

  flag_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf && wr_intctl) |=> s_q.intctl[INT_FLAG_BIT])
    else $error("same-cycle clear beat the overflow set");

  stall_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_count |=> (s_q.stall == STALL_CYCLES))
    else $error("count write did not arm the stall");

  stall_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.stall != 2'h0) |-> !inc)
    else $error("count advanced during stall");

  err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr)
    else $error("unmapped access without error");
endmodule

// file: tb/ebtc_pulse_src.sv
// Far-side model: a pulse source on the external count pin.
// Assumes burst is called just after a rising edge of pclk.
`timescale 1ns/1ps
module ebtc_pulse_src (
  input  wire logic pclk,
  output logic      ext_count_input
);
  // Idles low, a clean digital level only
  initial ext_count_input = 1'b0;
  // ==========
  // Burst of n pulses, each level held half cycles
  task automatic burst(input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      ext_count_input <= ~ext_count_input;
      repeat (half) @(posedge pclk);
    end
  endtask
endmodule

// file: tb/ebtc_tb.sv
// Testbench: APB driver noting expected reads in a queue, read monitor.
// Assumes ebtc_pkg, ebtc_top and ebtc_pulse_src are compiled first.
`timescale 1ns/1ps
module testbench;
  import ebtc_pkg::*;
  localparam logic [11:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [11:0] A_INT = {IDX_INTCTL, 2'b00};
  localparam logic [11:0] A_OPT = {IDX_OPTION, 2'b00};
  localparam logic [11:0] A_ST  = {IDX_STATUS, 2'b00};
  localparam logic [11:0] A_CLR = {IDX_CLEAR, 2'b00};
  localparam logic [11:0] A_EN  = {IDX_ENABLE, 2'b00};
  logic              pclk, presetn, psel, penable, pwrite, sleep_mode;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              pready, pslverr, overflow_int_req, irq, ext_count_input;
  logic [33:0]       expq[$];
  logic [33:0]       e;
  logic [7:0]        base;
  logic [31:0]       rnd;
  logic [31:0]       seed = 32'hacec2a50;
  int                n_errors = 0;
  int                checks = 0;

  ebtc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleep_mode, .ext_count_input, .overflow_int_req, .irq);
  ebtc_pulse_src src (.pclk, .ext_count_input);

  // ==========
  // Shared tasks
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic exp, input logic got);
    cmp({32'h0, exp}, {32'h0, got});
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Skip bit set: read only fetches a value for later use
  task automatic rdx(input logic [11:0] a, input logic [7:0] v, input logic s = 0, input logic er = 0);
    expq.push_back({s, er, 24'h0, v});
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic rate(input logic [7:0] opt, input int p);
    apb(A_OPT, 1'b1, {24'h0, opt});
    apb(A_CNT, 1'b1, 32'h0);
    repeat (2 * p + 16) @(posedge pclk);
    rdx(A_CNT, 8'h0, 1'b1);
    base = rd[7:0];
    repeat (2 * p - 3) @(posedge pclk);
    rdx(A_CNT, base + 8'd2);
  endtask
  task automatic ext(input logic [7:0] opt, input int n, input logic [7:0] exp);
    apb(A_OPT, 1'b1, {24'h0, opt});
    repeat (8) @(posedge pclk);
    apb(A_CNT, 1'b1, 32'h0);
    repeat (12) @(posedge pclk);
    src.burst(n, 8);
    repeat (24) @(posedge pclk);
    rdx(A_CNT, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========
  // Read monitor and watchdog
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = expq.pop_front();
      if (!e[33])
        cmp(e[32:0], {pslverr, prdata});
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    print_verdict;
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ==========
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, sleep_mode} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdx(A_OPT, OPTION_RST);
    rdx(A_INT, INTCTL_RST);
    rdx(12'h3fc, 8'h0, 1'b0, 1'b1);
    $display("reset and map done");
    rate(8'h08, 4);
    for (int r = 0; r < 8; r++)
      rate(r[7:0], 4 << (r + 1));
    $display("timer rates done");
    apb(A_CNT, 1'b1, 32'h40);
    repeat (2) @(posedge pclk);
    rdx(A_CNT, 8'h40);
    ext(8'h28, 5, 8'h05);
    ext(8'h38, 6, 8'h06);
    ext(8'h20, 8, 8'h04);
    $display("counter mode done");
    apb(A_OPT, 1'b1, 32'h08);
    apb(A_INT, 1'b1, 32'h0);
    apb(A_CNT, 1'b1, 32'hfe);
    repeat (30) @(posedge pclk);
    chk(1'b0, overflow_int_req);
    rdx(A_INT, 8'h04);
    rdx(A_ST, 8'h01);
    chk(1'b0, irq);
    apb(A_EN, 1'b1, 32'h1);
    chk(1'b1, irq);
    apb(A_INT, 1'b1, 32'h24);
    chk(1'b1, overflow_int_req);
    apb(A_CLR, 1'b1, 32'h1);
    chk(1'b0, irq);
    apb(A_INT, 1'b1, 32'h20);
    chk(1'b0, overflow_int_req);
    $display("overflow done");
    sleep_mode <= 1'b1;
    rdx(A_CNT, 8'h0, 1'b1);
    base = rd[7:0];
    repeat (40) @(posedge pclk);
    rdx(A_CNT, base);
    for (int i = 0; i < 4; i++) begin
      rnd = xs();
      apb(A_CNT, 1'b1, rnd);
      rdx(A_CNT, rnd[7:0]);
      apb(A_OPT, 1'b1, {rnd[7:0], rnd[31:8]});
      rdx(A_OPT, rnd[15:8]);
    end
    $display("sleep and access done");
    print_verdict;
  end
endmodule
